// ==== hdl/mam_addr_decode.sv ====
// address decoder mapping an apb byte address onto a readout slot
`timescale 1ns/1ps
`default_nettype none
module mam_addr_decode (
   // byte address from the bus
   input  wire logic [13:0] paddr_in,
   // decoded slot
   output logic             hit,
   output logic [2:0]       slot
);
   logic [11:0] idx;

   // word index; low two bits must be zero for an aligned word
   always_comb begin
      idx  = paddr_in[13:2];
      hit  = 1'b0;
      slot = 3'h0;
      if (paddr_in[1:0] == 2'h0) begin
         hit = 1'b1;
         case (idx)
            mam_pkg::IDX_SUPPLY_BUS_VOLTAGE:    slot = 3'(mam_pkg::SLOT_SUPPLY);
            mam_pkg::IDX_FIRST_PHASE_VOLTAGE:   slot = 3'(mam_pkg::SLOT_PH_A);
            mam_pkg::IDX_SECOND_PHASE_VOLTAGE:  slot = 3'(mam_pkg::SLOT_PH_B);
            mam_pkg::IDX_THIRD_PHASE_VOLTAGE:   slot = 3'(mam_pkg::SLOT_PH_C);
            mam_pkg::IDX_ROTOR_ANGLE_SINE:      slot = 3'(mam_pkg::SLOT_SINE);
            mam_pkg::IDX_ROTOR_ANGLE_COSINE:    slot = 3'(mam_pkg::SLOT_COSINE);
            mam_pkg::IDX_STATIONARY_ALPHA_CURR: slot = 3'(mam_pkg::SLOT_ALPHA);
            default:                            hit  = 1'b0;
         endcase
      end
   end
endmodule : mam_addr_decode
`default_nettype wire

// ==== hdl/mam_monitor_regs.sv ====
// apb slave exposing read-only motor algorithm monitoring registers
//
// Overview of operation
// - supply bus voltage readout, 32 bits, volts = value*60/2^27.
// - first phase voltage during initial speed detection, value*60/(sqrt3*2^27).
// - second phase voltage during initial speed detection, same scaling.
// - third phase voltage during initial speed detection, same scaling.
// - rotor angle sine, signed 32-bit, value/2^27.
// - rotor angle cosine, signed 32-bit, value/2^27.
// - alpha current readout at index 4d2, zero after reset.
// - alpha current signed, amps = value/2^27*base_current/8.
`timescale 1ns/1ps
`default_nettype none
module mam_monitor_regs (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [13:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // algorithm values (same clock domain), two's complement q5.27
   input  wire logic [31:0] supply_bus_voltage,
   input  wire logic [31:0] first_phase_voltage,
   input  wire logic [31:0] second_phase_voltage,
   input  wire logic [31:0] third_phase_voltage,
   input  wire logic [31:0] rotor_angle_sine,
   input  wire logic [31:0] rotor_angle_cosine,
   input  wire logic [31:0] stationary_alpha_current,
   // update strobes
   input  wire logic        supply_update,
   input  wire logic        initial_speed_detection,
   input  wire logic        angle_update,
   input  wire logic        alpha_update
);
   // ************************************************************
   // types and state
   // ************************************************************
   typedef enum logic [1:0] {MAM_IDLE, MAM_ANSWER} mam_phase_t;

   typedef struct packed {
      mam_phase_t  phase;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
   } mam_state_t;

   mam_state_t st_reg;
   mam_state_t st_next;

   localparam int unsigned N = mam_pkg::NUM_REGS;

   logic [N*32-1:0] bank_in;
   logic [N-1:0]    bank_vld;
   logic [N*32-1:0] bank_out;
   logic            dec_hit;
   logic [2:0]      dec_slot;

   // ************************************************************
   // algorithm capture
   // ************************************************************
   // phase voltages only change while speed detection runs
   always_comb begin
      bank_in  = '0;
      bank_vld = '0;
      bank_in[mam_pkg::SLOT_SUPPLY*32 +: 32] = supply_bus_voltage;
      bank_vld[mam_pkg::SLOT_SUPPLY]         = supply_update;
      bank_in[mam_pkg::SLOT_PH_A*32 +: 32]   = first_phase_voltage;
      bank_vld[mam_pkg::SLOT_PH_A]           = initial_speed_detection;
      bank_in[mam_pkg::SLOT_PH_B*32 +: 32]   = second_phase_voltage;
      bank_vld[mam_pkg::SLOT_PH_B]           = initial_speed_detection;
      bank_in[mam_pkg::SLOT_PH_C*32 +: 32]   = third_phase_voltage;
      bank_vld[mam_pkg::SLOT_PH_C]           = initial_speed_detection;
      bank_in[mam_pkg::SLOT_SINE*32 +: 32]   = rotor_angle_sine;
      bank_vld[mam_pkg::SLOT_SINE]           = angle_update;
      bank_in[mam_pkg::SLOT_COSINE*32 +: 32] = rotor_angle_cosine;
      bank_vld[mam_pkg::SLOT_COSINE]         = angle_update;
      bank_in[mam_pkg::SLOT_ALPHA*32 +: 32]  = stationary_alpha_current;
      bank_vld[mam_pkg::SLOT_ALPHA]          = alpha_update;
   end

   mam_sample_bank #(
      .N (N)
   ) u_bank (
      .pclk      (pclk),
      .presetn   (presetn),
      .value_in  (bank_in),
      .value_vld (bank_vld),
      .value_out (bank_out)
   );

   mam_addr_decode u_dec (
      .paddr_in (paddr),
      .hit      (dec_hit),
      .slot     (dec_slot)
   );

   // ************************************************************
   // apb access
   // ************************************************************
   // one wait state: answer registered so outputs come from flops
   always_comb begin
      st_next       = st_reg;
      st_next.ready = 1'b0;
      case (st_reg.phase)
         MAM_IDLE: begin
            if (psel && penable) begin
               st_next.phase = MAM_ANSWER;
               st_next.ready = 1'b1;
               st_next.rdata = mam_pkg::UNMAPPED_DATA;
               // writes never reach the bank, so values stay
               st_next.err   = pwrite || !dec_hit;
               if (!pwrite && dec_hit) begin
                  st_next.rdata = bank_out[dec_slot*32 +: 32];
               end
            end
         end
         MAM_ANSWER: begin
            // transfer completes this edge; drop the answer
            st_next.phase = MAM_IDLE;
            st_next.rdata = mam_pkg::UNMAPPED_DATA;
            st_next.err   = 1'b0;
         end
         default: begin
            st_next.phase = MAM_IDLE;
         end
      endcase
   end

   // single register stage for all bus state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '{phase: MAM_IDLE, rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata  = st_reg.rdata;
   assign pready  = st_reg.ready;
   assign pslverr = st_reg.err;
endmodule : mam_monitor_regs
`default_nettype wire

// ==== hdl/mam_sample_bank.sv ====
// bank of readout holding registers, one per monitored algorithm variable
`timescale 1ns/1ps
`default_nettype none
module mam_sample_bank #(
   parameter int unsigned N = 7
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // algorithm side: value and one-cycle update strobe per slot
   input  wire logic [N*32-1:0]   value_in,
   input  wire logic [N-1:0]      value_vld,
   // held values
   output logic [N*32-1:0]        value_out
);
   typedef struct packed {
      logic [N*32-1:0] held;
   } mam_bank_state_t;

   mam_bank_state_t st_reg;
   mam_bank_state_t st_next;

   // only the algorithm updates a slot; the bus has no path in here
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < N; i++) begin
         if (value_vld[i]) begin
            st_next.held[i*32 +: 32] = value_in[i*32 +: 32];
         end
      end
   end

   // zero after reset for every slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign value_out = st_reg.held;
endmodule : mam_sample_bank
`default_nettype wire

// ==== include/mam_pkg.sv ====
// package of offsets, reset values and scaling constants for the monitor register bank
package mam_pkg;
   // ************************************************************
   // bus and data geometry
   // ************************************************************
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned ADDR_W    = 12;
   localparam int unsigned FRAC_BITS = 27;   // fixed-point fraction width
   localparam int unsigned VOLT_FULL = 60;   // full-scale volts for voltage readouts
   localparam int unsigned CURR_DIV  = 8;    // base current divisor for current readouts
   localparam int unsigned NUM_REGS  = 7;

   // ************************************************************
   // printed offsets are register indices; byte address is four times
   // ************************************************************
   localparam logic [ADDR_W-1:0] IDX_SUPPLY_BUS_VOLTAGE     = 12'h476;
   localparam logic [ADDR_W-1:0] IDX_FIRST_PHASE_VOLTAGE    = 12'h47a;
   localparam logic [ADDR_W-1:0] IDX_SECOND_PHASE_VOLTAGE   = 12'h47c;
   localparam logic [ADDR_W-1:0] IDX_THIRD_PHASE_VOLTAGE    = 12'h47e;
   localparam logic [ADDR_W-1:0] IDX_ROTOR_ANGLE_SINE       = 12'h4b6;
   localparam logic [ADDR_W-1:0] IDX_ROTOR_ANGLE_COSINE     = 12'h4b8;
   localparam logic [ADDR_W-1:0] IDX_STATIONARY_ALPHA_CURR  = 12'h4d2;

   // register slot numbers in the readout array
   localparam int unsigned SLOT_SUPPLY = 0;
   localparam int unsigned SLOT_PH_A   = 1;
   localparam int unsigned SLOT_PH_B   = 2;
   localparam int unsigned SLOT_PH_C   = 3;
   localparam int unsigned SLOT_SINE   = 4;
   localparam int unsigned SLOT_COSINE = 5;
   localparam int unsigned SLOT_ALPHA  = 6;

   localparam logic [DATA_W-1:0] READOUT_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : mam_pkg

// ==== testbench/mam_monitor_regs_monitor.sv ====
// assertion checker for the monitor register bank bus port
`timescale 1ns/1ps
`default_nettype none
module mam_regs_checker (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // algorithm side
   input wire logic [31:0] supply_bus_voltage,
   input wire logic        supply_update,
   input wire logic        alpha_update
);
   logic [31:0] sup_q;
   logic        alpha_seen;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // shadow of the supply readout; alpha flag tells whether it can still read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_q      <= '0;
         alpha_seen <= 1'b0;
      end else begin
         if (supply_update) sup_q <= supply_bus_voltage;
         if (alpha_update) alpha_seen <= 1'b1;
      end
   end

   ready_wait_a: assert property (psel && penable && !pready && !$past(penable) |=> pready)
      else $error("ready not one cycle after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   no_spurious_a: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   write_refused_a: assert property (pready && pwrite |-> pslverr && prdata == '0)
      else $error("write not refused");
   idle_quiet_a: assert property (!pready |-> prdata == '0 && !pslverr)
      else $error("outputs not quiet when idle");
   misaligned_err_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access accepted");
   sine_ok_a: assert property (pready && !pwrite && paddr == 14'h12d8 |-> !pslverr)
      else $error("sine read refused");
   supply_value_a: assert property (pready && !pwrite && paddr == 14'h11d8 &&
      !$past(supply_update) |-> prdata == sup_q)
      else $error("supply readout wrong");
   alpha_reset_a: assert property (pready && !pwrite && paddr == 14'h1348 &&
      !alpha_seen |-> prdata == '0)
      else $error("alpha readout not zero");
endmodule : mam_regs_checker
bind mam_monitor_regs mam_regs_checker mam_regs_checker_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .supply_bus_voltage, .supply_update,
   .alpha_update);
`default_nettype wire

// ==== testbench/mam_monitor_regs_tb.sv ====
// self-checking bench for the monitor register bank
`timescale 1ns/1ps
`default_nettype none
module mam_monitor_regs_tb;
   logic        pclk, presetn, psel, penable, pwrite, e;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, d, r;
   logic        pready, pslverr;
   logic [31:0] val [7];
   logic [31:0] exp_v [7];
   logic [3:0]  upd, u;
   logic [13:0] adr [7] = '{14'h11d8, 14'h11e8, 14'h11f0, 14'h11f8, 14'h12d8, 14'h12e0, 14'h1348};
   integer      seed = 69, n_mismatch = 0, n_tests = 0;

   mam_monitor_regs mam_monitor_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_bus_voltage(val[0]),
      .first_phase_voltage(val[1]), .second_phase_voltage(val[2]),
      .third_phase_voltage(val[3]), .rotor_angle_sine(val[4]), .rotor_angle_cosine(val[5]),
      .stationary_alpha_current(val[6]), .supply_update(upd[0]),
      .initial_speed_detection(upd[1]), .angle_update(upd[2]), .alpha_update(upd[3]));

   // which strobe captures slot k
   function automatic logic strobe_of(input int k, input logic [3:0] s);
      return s[(k == 0) ? 0 : (k < 4) ? 1 : (k < 6) ? 2 : 3];
   endfunction : strobe_of

   // one apb transfer; holds the request until ready is sampled high or 20 cycles pass
   task automatic apb(input logic wr, input logic [13:0] a);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= $random(seed);
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk) n++; while (pready !== 1'b1 && n < 20);
      // a slave that never answers is a failure, not a silent stale read
      if (pready !== 1'b1) n_mismatch++;
      d = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic chk_w(input string nm, input logic [31:0] ex, got);
      n_tests++;
      if (got !== ex) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, ex, got); end
   endtask : chk_w

   task automatic chk_b(input string nm, input logic ex, got);
      n_tests++;
      if (got !== ex) begin n_mismatch++; $display("BAD %s exp %b got %b", nm, ex, got); end
   endtask : chk_b

   task automatic rd_all();
      for (int k = 0; k < 7; k++) begin
         apb(1'b0, adr[k]);
         chk_w("readout", exp_v[k], d);
         chk_b("read err", 1'b0, e);
      end
   endtask : rd_all

   task automatic summarize();
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      summarize();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; upd = '0;
      for (int k = 0; k < 7; k++) begin val[k] = '0; exp_v[k] = '0; end
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd_all();
      // random captures, extremes first; values move again on the same edge the strobe drops
      for (int i = 0; i < 40; i++) begin
         @(posedge pclk);
         u = (i < 2) ? 4'hf : 4'($random(seed));
         upd <= u;
         for (int k = 0; k < 7; k++) begin
            r = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'h7fff_ffff : $random(seed);
            val[k] <= r;
            if (strobe_of(k, u)) exp_v[k] = r;
         end
         @(posedge pclk);
         upd <= '0;
         for (int k = 0; k < 7; k++) val[k] <= ~val[k];
         apb(1'b1, adr[i % 7]);
         chk_b("write err", 1'b1, e);
         chk_w("write data", '0, d);
         rd_all();
      end
      // unmapped and misaligned reads
      apb(1'b0, 14'h11dc);
      chk_b("unmapped err", 1'b1, e);
      chk_w("unmapped data", '0, d);
      apb(1'b0, 14'h11d9);
      chk_b("misaligned err", 1'b1, e);
      chk_w("misaligned data", '0, d);
      summarize();
   end
endmodule : mam_monitor_regs_tb
`default_nettype wire
